// ### src/standard_pwm_generator.sv
`timescale 1ns/1ps

// Summary of operation
// - Period is (period_limit+1) times four oscillator clocks times prescale.
// - After count equals period_limit: clear count, set pin unless 0%, load shadow.
// - Postscaler setting never alters the PWM period.
// - Duty is 10 bits: high byte plus two low control bits.
// - Duty writes accepted anytime, take effect at next period restart.
// - Shadow duty byte is read-only while in PWM mode.
// - High time equals duty times one oscillator clock times prescale.
// - Active duty is double buffered in shadow byte and hidden latch.
// - Time base is count plus two clock-phase or prescaler bits.
// - Pin driven low when time base equals buffered duty.
// - Resolution is log2 of 4*(period_limit+1), ten bits at 255.
// - Duty beyond the period leaves the pin unchanged.
// - During sleep the timer and PWM latch freeze; pin holds, counting resumes afterwards.
// - Reset makes the pin an input and restores all registers.
// - PWM frequency follows the system clock proportionally.
// - Timer counts only while enabled; prescale from its select field.
// - Mode values with both upper bits set select PWM operation.
// - Mode value zero turns the unit off, clearing the PWM latch and shadow low bits.
module standard_pwm_generator #(
	parameter int COUNT_W = 8,
	parameter int DUTY_LOW_W = 2
) (
	input wire logic core_clk, // system clock, 250 MHz
	input wire logic rst, // synchronous reset, active high
	input wire logic sleep, // device asleep: freeze the unit
	input wire pwm_unit_pkg::apb_req_s apb_req, // APB request
	output logic [31:0] prdata, // APB read data
	output logic pready, // APB ready
	output logic pslverr, // APB error on unmapped address
	output logic unit_output_pin, // output pin level
	output logic unit_output_pin_oe_n, // pin driver enable, low drives
	output logic base_timer_match_flag // sticky period match flag
);
	import pwm_unit_pkg::*;

	initial
	begin
		if (COUNT_W != 8 || DUTY_LOW_W != 2)
			$error("standard_pwm_generator: only 8+2 bit time base");
	end

	////////////////////////////////////////////////////////////////////////
	// State

	typedef struct packed {
		logic [3:0] unit_mode_sel;
		logic [1:0] duty_low_bits;
		logic [7:0] duty_high_byte;
		logic [7:0] duty_shadow_high;
		logic [1:0] duty_shadow_low;
		logic [7:0] timer_assignment_sel;
		logic [7:0] period_limit;
		logic [4:0] pin_output_source_sel;
		logic [3:0] base_timer_postscale_sel;
		logic base_timer_on;
		logic [1:0] base_timer_prescale_sel;
		logic [7:0] base_timer_count;
		logic [7:0] pre_count;
		logic [3:0] post_count;
		logic match_flag;
		logic pin_direction_bit;
		logic pwm_latch;
		logic pin_out;
		logic pin_oe_n;
		logic pready;
		logic pslverr;
		logic [31:0] prdata;
	} unit_state_s;

	unit_state_s state;
	unit_state_s next_state;

	////////////////////////////////////////////////////////////////////////
	// Helpers

	logic pwm_mode;
	logic mode_off;
	logic [7:0] tick_last;
	logic [1:0] next_phase_bits;
	logic tick;
	logic period_match;
	logic [9:0] next_time_base;
	logic [9:0] duty_active;
	logic [9:0] duty_written;
	logic access;
	logic wr_en;
	logic rd_en;
	logic addr_ok;
	logic [31:0] rd_value;

	always_comb
	begin
		pwm_mode = (state.unit_mode_sel[3:2] == MODE_PWM_TOP);
		mode_off = (state.unit_mode_sel == MODE_OFF);

		// four clocks per tick times prescale
		case (state.base_timer_prescale_sel)
			PRESCALE_1: tick_last = TICK_LAST_1;
			PRESCALE_4: tick_last = TICK_LAST_4;
			PRESCALE_16: tick_last = TICK_LAST_16;
			default: tick_last = TICK_LAST_64;
		endcase

		tick = state.base_timer_on && !sleep &&
			(state.pre_count >= tick_last);
		period_match = tick &&
			(state.base_timer_count == state.period_limit);

		duty_written = {state.duty_high_byte, state.duty_low_bits};
		// active duty from shadow and latch
		duty_active = {state.duty_shadow_high, state.duty_shadow_low};
	end

	////////////////////////////////////////////////////////////////////////
	// APB decode

	always_comb
	begin
		access = apb_req.psel && apb_req.penable;
		wr_en = access && state.pready && apb_req.pwrite;
		rd_en = access && !state.pready && !apb_req.pwrite;

		addr_ok = 1'b1;
		rd_value = '0;
		case (apb_req.paddr)
			ADDR_UNIT_CONTROL:
			begin
				rd_value[MODE_LSB +: 4] = state.unit_mode_sel;
				rd_value[DUTY_LOW_LSB +: 2] = state.duty_low_bits;
			end
			ADDR_DUTY_HIGH: rd_value[7:0] = state.duty_high_byte;
			ADDR_DUTY_SHADOW: rd_value[7:0] = state.duty_shadow_high;
			ADDR_TIMER_ASSIGN: rd_value[7:0] = state.timer_assignment_sel;
			ADDR_PERIOD_LIMIT: rd_value[7:0] = state.period_limit;
			ADDR_PIN_SOURCE: rd_value[4:0] = state.pin_output_source_sel;
			ADDR_TIMER_CONTROL:
			begin
				rd_value[PRESCALE_LSB +: 2] = state.base_timer_prescale_sel;
				rd_value[TIMER_ON_BIT] = state.base_timer_on;
				rd_value[POSTSCALE_LSB +: 4] =
					state.base_timer_postscale_sel;
			end
			ADDR_TIMER_COUNT: rd_value[7:0] = state.base_timer_count;
			ADDR_PIN_DIRECTION:
				rd_value[DIRECTION_BIT] = state.pin_direction_bit;
			ADDR_TIMER_STATUS: rd_value[FLAG_BIT] = state.match_flag;
			default: addr_ok = 1'b0;
		endcase
	end

	////////////////////////////////////////////////////////////////////////
	// Next state

	always_comb
	begin
		next_state = state;

		// One wait state so read data can come from a flop
		next_state.pready = access && !state.pready;
		next_state.pslverr = access && !state.pready && !addr_ok;
		if (rd_en)
			next_state.prdata = rd_value;

		// Software writes, taken at the completing edge
		// duty writes accepted at any time
		if (wr_en && addr_ok)
		begin
			case (apb_req.paddr)
				ADDR_UNIT_CONTROL:
				begin
					next_state.unit_mode_sel =
						apb_req.pwdata[MODE_LSB +: 4];
					next_state.duty_low_bits =
						apb_req.pwdata[DUTY_LOW_LSB +: 2];
				end
				ADDR_DUTY_HIGH:
					next_state.duty_high_byte = apb_req.pwdata[7:0];
				ADDR_DUTY_SHADOW:
				begin
					if (!pwm_mode)
						next_state.duty_shadow_high = apb_req.pwdata[7:0];
				end
				ADDR_TIMER_ASSIGN:
					next_state.timer_assignment_sel = apb_req.pwdata[7:0];
				ADDR_PERIOD_LIMIT:
					next_state.period_limit = apb_req.pwdata[7:0];
				ADDR_PIN_SOURCE:
					next_state.pin_output_source_sel = apb_req.pwdata[4:0];
				ADDR_TIMER_CONTROL:
				begin
					next_state.base_timer_prescale_sel =
						apb_req.pwdata[PRESCALE_LSB +: 2];
					next_state.base_timer_on = apb_req.pwdata[TIMER_ON_BIT];
					next_state.base_timer_postscale_sel =
						apb_req.pwdata[POSTSCALE_LSB +: 4];
				end
				ADDR_TIMER_COUNT:
					next_state.base_timer_count = apb_req.pwdata[7:0];
				ADDR_PIN_DIRECTION:
					next_state.pin_direction_bit =
						apb_req.pwdata[DIRECTION_BIT];
				ADDR_TIMER_STATUS:
				begin
					// Write one clears; a match in the same cycle wins below
					if (apb_req.pwdata[FLAG_BIT])
						next_state.match_flag = 1'b0;
				end
				default: next_state.match_flag = state.match_flag;
			endcase
		end

		if (!sleep && state.base_timer_on)
		begin
			if (tick)
			begin
				// phase bits restart with the count
				next_state.pre_count = '0;
				if (period_match)
				begin
					next_state.base_timer_count = '0;
					if (state.post_count == state.base_timer_postscale_sel)
					begin
						next_state.post_count = '0;
						next_state.match_flag = 1'b1;
					end
					else
						next_state.post_count = state.post_count + 4'h1;
				end
				else
					next_state.base_timer_count =
						state.base_timer_count + 8'h01;
			end
			else
				next_state.pre_count = state.pre_count + 8'h01;
		end

		// clock phase or prescaler bits below the count
		case (next_state.base_timer_prescale_sel)
			PRESCALE_1: next_phase_bits = next_state.pre_count[1:0];
			PRESCALE_4: next_phase_bits = next_state.pre_count[3:2];
			PRESCALE_16: next_phase_bits = next_state.pre_count[5:4];
			default: next_phase_bits = next_state.pre_count[7:6];
		endcase
		// ten-bit time base as it stands after this edge
		next_time_base = {next_state.base_timer_count, next_phase_bits};

		if (!sleep && pwm_mode)
		begin
			if (period_match)
			begin
				next_state.duty_shadow_high = state.duty_high_byte;
				next_state.duty_shadow_low = state.duty_low_bits;
				// pin set unless duty is zero
				next_state.pwm_latch = (duty_written != '0);
			end
			// Cleared one edge early: latch is low once the base hits duty
			else if (next_time_base == duty_active)
			begin
				// high time is duty times prescale clocks
				// no match inside the period keeps the pin
				next_state.pwm_latch = 1'b0;
			end
		end

		if (mode_off)
		begin
			next_state.pwm_latch = 1'b0;
			next_state.duty_shadow_low = '0;
		end

		// Pin follows the unit only when routed and in PWM mode
		next_state.pin_out = pwm_mode && state.pwm_latch &&
			(state.pin_output_source_sel == PIN_SOURCE_THIS_UNIT);
		next_state.pin_oe_n = state.pin_direction_bit;
	end

	////////////////////////////////////////////////////////////////////////
	// Registers

	always_ff @(posedge core_clk)
	begin
		if (rst)
		begin
			state <= '0;
			state.pin_direction_bit <= RESET_DIRECTION_INPUT;
			state.pin_oe_n <= RESET_DIRECTION_INPUT;
		end
		else
			state <= next_state;
	end

	// resolution follows period_limit through the time base
	assign prdata = state.prdata;
	assign pready = state.pready;
	assign pslverr = state.pslverr;
	assign unit_output_pin = state.pin_out;
	assign unit_output_pin_oe_n = state.pin_oe_n;
	assign base_timer_match_flag = state.match_flag;

endmodule : standard_pwm_generator

// ### src/pwm_unit_pkg.sv
package pwm_unit_pkg;

	// APB request bundle from the bus master
	typedef struct packed {
		logic psel;
		logic penable;
		logic pwrite;
		logic [11:0] paddr;
		logic [31:0] pwdata;
	} apb_req_s;

	localparam int ADDR_W = 12;
	localparam int DATA_W = 32;

	// Register byte addresses
	localparam logic [11:0] ADDR_UNIT_CONTROL = 12'h000;
	localparam logic [11:0] ADDR_DUTY_HIGH = 12'h004;
	localparam logic [11:0] ADDR_DUTY_SHADOW = 12'h008;
	localparam logic [11:0] ADDR_TIMER_ASSIGN = 12'h00C;
	localparam logic [11:0] ADDR_PERIOD_LIMIT = 12'h010;
	localparam logic [11:0] ADDR_PIN_SOURCE = 12'h014;
	localparam logic [11:0] ADDR_TIMER_CONTROL = 12'h018;
	localparam logic [11:0] ADDR_TIMER_COUNT = 12'h01C;
	localparam logic [11:0] ADDR_PIN_DIRECTION = 12'h020;
	localparam logic [11:0] ADDR_TIMER_STATUS = 12'h024;

	// pwm_unit_control fields
	localparam int MODE_LSB = 0;
	localparam int DUTY_LOW_LSB = 4;
	// base_timer_control fields
	localparam int PRESCALE_LSB = 0;
	localparam int TIMER_ON_BIT = 2;
	localparam int POSTSCALE_LSB = 3;
	// Single-bit registers sit in bit 0
	localparam int FLAG_BIT = 0;
	localparam int DIRECTION_BIT = 0;

	// Mode select codes
	localparam logic [3:0] MODE_OFF = 4'h0;
	localparam logic [1:0] MODE_PWM_TOP = 2'h3;

	// Prescale select codes: 1:1, 1:4, 1:16, 1:64
	localparam logic [1:0] PRESCALE_1 = 2'h0;
	localparam logic [1:0] PRESCALE_4 = 2'h1;
	localparam logic [1:0] PRESCALE_16 = 2'h2;

	// Timer ticks once per four oscillator periods times the prescale
	localparam int OSC_PER_TICK = 4;
	localparam logic [7:0] TICK_LAST_1 = 8'h03;
	localparam logic [7:0] TICK_LAST_4 = 8'h0F;
	localparam logic [7:0] TICK_LAST_16 = 8'h3F;
	localparam logic [7:0] TICK_LAST_64 = 8'hFF;

	// Source code that routes this unit to the pin (arbitrary value)
	localparam logic [4:0] PIN_SOURCE_THIS_UNIT = 5'h0C;

	// Reset values
	localparam logic [7:0] RESET_BYTE = 8'h00;
	localparam logic RESET_DIRECTION_INPUT = 1'b1;

	// Clock figure
	localparam real CORE_CLK_NS = 4.0;

endpackage : pwm_unit_pkg

// ### tb/standard_pwm_generator_checker.sv
`timescale 1ns/1ps
module standard_pwm_generator_checker
	import pwm_unit_pkg::*;
(
	input wire logic core_clk, // clock
	input wire logic rst, // reset
	input wire logic sleep, // freeze
	input wire pwm_unit_pkg::apb_req_s apb_req, // bus request
	input wire logic [31:0] prdata, // read data
	input wire logic pready, // ready
	input wire logic pslverr, // error
	input wire logic unit_output_pin, // pin level
	input wire logic unit_output_pin_oe_n, // driver enable
	input wire logic base_timer_match_flag // match flag
);
	logic wr_hit;
	logic clr_hit;
	logic dir_hit;
	assign wr_hit = pready && apb_req.psel && apb_req.penable && apb_req.pwrite;
	assign clr_hit = wr_hit && apb_req.paddr == ADDR_TIMER_STATUS
		&& apb_req.pwdata[FLAG_BIT];
	assign dir_hit = wr_hit && apb_req.paddr == ADDR_PIN_DIRECTION;
	default clocking @(posedge core_clk);
	endclocking
	default disable iff (rst);
	////////////////////////////////////////////////////////////
	sequence s_setup;
		apb_req.psel && !apb_req.penable;
	endsequence
	sequence s_access;
		apb_req.psel && apb_req.penable;
	endsequence
	property p_ready_timing;
		s_setup ##1 s_access |=> pready;
	endproperty
	property p_ready_pulse;
		pready |=> !pready;
	endproperty
	property p_err_refused;
		pslverr |-> pready && (apb_req.pwrite || prdata == 32'h0);
	endproperty
	property p_reset_state;
		disable iff (1'b0) rst |=> unit_output_pin_oe_n && !unit_output_pin
			&& !base_timer_match_flag && !pready;
	endproperty
	property p_sleep_pin;
		sleep ##1 sleep |=> $stable(unit_output_pin);
	endproperty
	property p_sleep_flag;
		sleep ##1 sleep |=> $stable(base_timer_match_flag);
	endproperty
	property p_flag_sticky;
		base_timer_match_flag && !clr_hit |=> base_timer_match_flag;
	endproperty
	property p_oe_follow;
		dir_hit |-> ##2
			unit_output_pin_oe_n == $past(apb_req.pwdata[DIRECTION_BIT], 2);
	endproperty
	a_ready_timing: assert property (p_ready_timing)
		else $error("ready late");
	a_ready_pulse: assert property (p_ready_pulse)
		else $error("ready too long");
	a_err_refused: assert property (p_err_refused)
		else $error("bad error response");
	a_reset_state: assert property (p_reset_state)
		else $error("reset state wrong");
	a_sleep_pin: assert property (p_sleep_pin)
		else $error("pin moved in sleep");
	a_sleep_flag: assert property (p_sleep_flag)
		else $error("flag moved in sleep");
	a_flag_sticky: assert property (p_flag_sticky)
		else $error("flag dropped");
	a_oe_follow: assert property (p_oe_follow)
		else $error("driver enable wrong");
endmodule : standard_pwm_generator_checker

bind standard_pwm_generator standard_pwm_generator_checker checker_inst (
	.core_clk(core_clk), .rst(rst), .sleep(sleep), .apb_req(apb_req),
	.prdata(prdata), .pready(pready), .pslverr(pslverr),
	.unit_output_pin(unit_output_pin),
	.unit_output_pin_oe_n(unit_output_pin_oe_n),
	.base_timer_match_flag(base_timer_match_flag));

// ### tb/pwm_load.sv
`timescale 1ns/1ps
module pwm_load (
	input wire logic core_clk, // clock
	input wire logic pin, // driven level
	input wire logic oe_n, // low while driven
	output int high_cycles, // cycles seen high
	output int rises // rising edges seen
);
	logic level;
	logic last = 1'b0;
	// Released pin is pulled down by the load
	assign level = oe_n ? 1'b0 : pin;
	initial
	begin
		high_cycles = 0;
		rises = 0;
	end
	always @(posedge core_clk)
	begin
		if (level === 1'b1)
			high_cycles <= high_cycles + 1;
		if (level === 1'b1 && last !== 1'b1)
			rises <= rises + 1;
		last <= level;
	end
endmodule : pwm_load

// ### tb/standard_pwm_generator_tb.sv
`timescale 1ns/1ps
module standard_pwm_generator_tb;
	import pwm_unit_pkg::*;
	logic core_clk = 1'b0;
	logic rst = 1'b1;
	logic sleep = 1'b0;
	apb_req_s req = '0;
	logic [31:0] prdata, r;
	logic pready, pslverr, pin, oe_n, flag, e;
	int high_cycles, rises, n, failures = 0, tests_run = 0;
	logic [15:0] seed = 16'h0028;
	logic [7:0] pl;
	logic [9:0] duty;
	logic [1:0] ps;
	logic [3:0] mode;
	standard_pwm_generator standard_pwm_generator_inst (.core_clk(core_clk),
		.rst(rst), .sleep(sleep), .apb_req(req), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .unit_output_pin(pin),
		.unit_output_pin_oe_n(oe_n), .base_timer_match_flag(flag));
	pwm_load pwm_load_inst (.core_clk(core_clk), .pin(pin), .oe_n(oe_n),
		.high_cycles(high_cycles), .rises(rises));
	always #2 core_clk = ~core_clk;
	////////////////////////////////////////////////////////////
	function automatic logic [15:0] lfsr(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction : lfsr
	task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] g);
		tests_run++;
		if (g !== x)
		begin
			failures++;
			$display("[FAIL] %s expected %h seen %h", nm, x, g);
		end
	endtask : chk
	task automatic print_verdict;
		if (failures == 0 && tests_run > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : print_verdict
	task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
		int k;
		@(posedge core_clk);
		req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
		@(posedge core_clk);
		req.penable <= 1'b1;
		k = 0;
		do
		begin
			@(posedge core_clk);
			k++;
		end while (pready !== 1'b1 && k < 20);
		r = prdata;
		e = pslverr;
		req.psel <= 1'b0;
		req.penable <= 1'b0;
		// Hung slave ends the run here
		if (pready !== 1'b1)
		begin
			failures++;
			print_verdict();
		end
	endtask : xfer
	task automatic rd(input string nm, input logic [11:0] a, input logic [31:0] x);
		xfer(1'b0, a, 32'h0);
		chk(nm, x, r);
	endtask : rd
	task automatic run_case;
		int per, eh, er, h0, r0;
		per = (int'(pl) + 1) * 4 * (1 << (2 * ps));
		eh = (duty >= 4 * (int'(pl) + 1)) ? per : int'(duty) * (1 << (2 * ps));
		er = (duty == 10'h0 || eh == per || mode[3:2] != 2'h3) ? 0 : 2;
		eh = (mode[3:2] == 2'h3) ? eh : 0;
		xfer(1'b1, ADDR_TIMER_CONTROL, 32'h0);
		xfer(1'b1, ADDR_TIMER_COUNT, 32'h0);
		xfer(1'b1, ADDR_PERIOD_LIMIT, {24'h0, pl});
		xfer(1'b1, ADDR_UNIT_CONTROL, {26'h0, duty[1:0], mode});
		xfer(1'b1, ADDR_DUTY_HIGH, {24'h0, duty[9:2]});
		xfer(1'b1, ADDR_TIMER_CONTROL, {25'h0, seed[11:8], 1'b1, ps});
		// First period may be partial, so settle first
		repeat (3 * per) @(posedge core_clk);
		h0 = high_cycles;
		r0 = rises;
		repeat (2 * per) @(posedge core_clk);
		chk("high time", 32'(2 * eh), 32'(high_cycles - h0));
		chk("pulses", 32'(er), 32'(rises - r0));
		if (mode[3:2] == 2'h3)
		begin
			xfer(1'b1, ADDR_DUTY_SHADOW, 32'hA5);
			rd("shadow", ADDR_DUTY_SHADOW, {24'h0, duty[9:2]});
		end
	endtask : run_case
	////////////////////////////////////////////////////////////
	initial
	begin
		repeat (12) @(posedge core_clk);
		rst <= 1'b0;
		for (int i = 0; i < 10; i++)
			rd("reset", 12'(4 * i), {31'h0, 12'(4 * i) == ADDR_PIN_DIRECTION});
		xfer(1'b0, 12'h028, 32'h0);
		chk("unmapped", 32'h1, {31'h0, e});
		xfer(1'b1, ADDR_PIN_SOURCE, {27'h0, PIN_SOURCE_THIS_UNIT});
		xfer(1'b1, ADDR_PIN_DIRECTION, 32'h0);
		repeat (2) @(posedge core_clk);
		chk("driver on", 32'h0, {31'h0, oe_n});
		for (int i = 0; i < 12; i++)
		begin
			seed = lfsr(seed);
			pl = {4'h0, seed[3:0]};
			ps = (seed[5:4] == 2'h3) ? 2'h1 : seed[5:4];
			mode = {2'h3, seed[7:6]};
			seed = lfsr(seed);
			duty = 10'(int'(seed) % (4 * (int'(pl) + 1) + 1));
			duty = (i == 0) ? 10'h0 : duty;
			duty = (i == 1) ? 10'(4 * (int'(pl) + 1)) : duty;
			duty = (i == 2) ? 10'(4 * int'(pl) + 3) : duty;
			ps = (i == 3) ? 2'h3 : ps;
			mode = (i == 4) ? 4'h8 : mode;
			run_case();
		end
		sleep <= 1'b1;
		xfer(1'b0, ADDR_TIMER_COUNT, 32'h0);
		repeat (30) @(posedge core_clk);
		rd("sleep hold", ADDR_TIMER_COUNT, r);
		sleep <= 1'b0;
		// Clear with the timer stopped so no match races the clear
		xfer(1'b1, ADDR_TIMER_CONTROL, 32'h0);
		xfer(1'b1, ADDR_TIMER_STATUS, 32'h1);
		rd("flag clear", ADDR_TIMER_STATUS, 32'h0);
		// Postscale 0 and 1:1 so the flag must come back quickly
		xfer(1'b1, ADDR_TIMER_CONTROL, 32'(1 << TIMER_ON_BIT));
		for (n = 0; n < 3000 && flag !== 1'b1; n++)
			@(posedge core_clk);
		chk("flag", 32'h1, {31'h0, flag});
		xfer(1'b1, ADDR_TIMER_CONTROL, 32'h0);
		xfer(1'b0, ADDR_TIMER_COUNT, 32'h0);
		repeat (30) @(posedge core_clk);
		rd("timer off", ADDR_TIMER_COUNT, r);
		xfer(1'b1, ADDR_UNIT_CONTROL, 32'h0);
		repeat (4) @(posedge core_clk);
		chk("mode off", 32'h0, {31'h0, pin});
		rst <= 1'b1;
		repeat (2) @(posedge core_clk);
		rst <= 1'b0;
		rd("reset again", ADDR_PIN_DIRECTION, 32'h1);
		print_verdict();
	end
endmodule : standard_pwm_generator_tb
